// ---- src/gpc_map.svh ----
// Purpose: register offsets, reset values and field sizes for the port 3 / port 4 configuration block
// Assumes: registers sit in the core's special-function register space, 8-bit address, 8-bit data
// Notes: included by the package and by gpc_ports; gpc_pin_cell does not include it
// Functional notes
// - port 3 drive-select bit is ignored while its input-config bit is 0 (analog).
// - port 3 pin drives open-drain when drive-select is 0, push-pull when 1.
// - crossbar passes over port 3 pins whose bypass bit is 1, uses those at 0.
// - writing port 4 data loads each output latch bit: 0 low, 1 high.
// - reading port 4 data returns present pin levels, not latch contents.
// - port 4 pin drives open-drain when drive-select is 0, push-pull when 1.
// - port 3 input-config 0 means analog: no weak pull-up, no digital receiver.
`ifndef GPC_MAP_SVH
`define GPC_MAP_SVH
`define GPC_ADDR_W          8
`define GPC_DATA_W          8
`define GPC_PINS            8
`define GPC_PORT3_DRIVE_OFS  8'hae
`define GPC_PORT4_DRIVE_OFS  8'haf
`define GPC_PORT4_DATA_OFS   8'hb5
`define GPC_PORT3_BYPASS_OFS 8'hd7
`define GPC_PORT3_DRIVE_RST  8'h00
`define GPC_PORT4_DRIVE_RST  8'h00
`define GPC_PORT4_DATA_RST   8'hff
`define GPC_PORT3_BYPASS_RST 8'h00
`define GPC_UNMAPPED_READ   8'h00
`endif

// ---- src/gpc_pin_cell.sv ----
// Purpose: output-drive logic for one port pin
// Assumes: drive_data is the pin's wanted level, push_pull selects the driver style
// Notes: open-drain only pulls low; a high level floats onto the external or weak pull-up
`timescale 1ns/100ps
module gpc_pin_cell
    import gpc_pkg::*;
(
    input  wire logic digital_en,
    input  wire logic push_pull,
    input  wire logic drive_data,
    input  wire logic pin_in,
    output logic      pin_out,
    output logic      pin_oe,
    output logic      pin_level,
    output logic      pullup_en
);
    gpc_pin_mode_type mode;

    always_comb
    begin
        if (!digital_en)
            mode = GPC_MODE_ANALOG;
        else if (push_pull)
            mode = GPC_MODE_PUSH_PULL;
        else
            mode = GPC_MODE_OPEN_DRAIN;
    end

    always_comb
    begin
        pin_out   = drive_data;
        pin_oe    = 1'b0;
        pullup_en = 1'b0;
        pin_level = 1'b0;
        unique case (mode)
            GPC_MODE_PUSH_PULL:
            begin
                pin_oe    = 1'b1;
                pullup_en = 1'b1;
                pin_level = pin_in;
            end
            GPC_MODE_OPEN_DRAIN:
            begin
                // drive low only; a high latch releases the pin
                pin_out   = 1'b0;
                pin_oe    = ~drive_data;
                pullup_en = 1'b1;
                pin_level = pin_in;
            end
            // receiver off in analog mode so a mid-rail voltage cannot toggle digital logic
            GPC_MODE_ANALOG:
            begin
                pin_out = 1'b0;
            end
            default:
            begin
                pin_out = 1'b0;
            end
        endcase
    end
endmodule : gpc_pin_cell

// ---- src/gpc_pkg.sv ----
// Purpose: shared types for the port 3 / port 4 configuration block
// Assumes: gpc_map.svh supplies the sizes
// Notes: types only
`include "gpc_map.svh"
package gpc_pkg;
    typedef logic [`GPC_DATA_W-1:0] gpc_byte_type;
    typedef logic [`GPC_ADDR_W-1:0] gpc_addr_type;
    typedef enum logic [1:0] {GPC_MODE_OPEN_DRAIN, GPC_MODE_PUSH_PULL, GPC_MODE_ANALOG} gpc_pin_mode_type;
endpackage : gpc_pkg

// ---- src/gpc_ports.sv ----
// Purpose: port 3 drive-select and crossbar bypass, port 4 data latch and drive-select registers with pin logic
// Assumes: one-cycle sfr write and read strobes synchronous to clock; pins already synchronous
// Notes: read data is registered, valid the cycle after the read strobe
`timescale 1ns/100ps
`include "gpc_map.svh"
module gpc_ports
    import gpc_pkg::*;
(
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic             sfr_wr,
    input  wire logic             sfr_rd,
    input  wire gpc_addr_type     sfr_addr,
    input  wire gpc_byte_type     sfr_wdata,
    output gpc_byte_type          sfr_rdata,
    input  wire gpc_byte_type     port3_input_config,
    input  wire gpc_byte_type     port3_data,
    input  wire gpc_byte_type     port3_pin_in,
    output gpc_byte_type          port3_pin_out,
    output gpc_byte_type          port3_pin_oe,
    output gpc_byte_type          port3_pullup_en,
    output gpc_byte_type          port3_digital_in,
    output gpc_byte_type          port3_crossbar_skip,
    input  wire gpc_byte_type     port4_pin_in,
    output gpc_byte_type          port4_pin_out,
    output gpc_byte_type          port4_pin_oe,
    output gpc_byte_type          port4_pullup_en
);
    gpc_byte_type port3_drive_select_q;
    gpc_byte_type port3_drive_select_d;
    gpc_byte_type port4_drive_select_q;
    gpc_byte_type port4_drive_select_d;
    gpc_byte_type port4_data_latch_q;
    gpc_byte_type port4_data_latch_d;
    gpc_byte_type port3_crossbar_bypass_q;
    gpc_byte_type port3_crossbar_bypass_d;
    gpc_byte_type rdata_q;
    gpc_byte_type rdata_d;
    gpc_byte_type read_mux;
    gpc_byte_type port4_level;
    gpc_byte_type port4_pin_out_c;
    gpc_byte_type port4_pin_oe_c;
    gpc_byte_type port4_pullup_c;
    logic         sel_port3_drive;
    logic         sel_port4_drive;
    logic         sel_port4_latch;
    logic         sel_port3_bypass;
    logic         sel_mapped;

    // one decode shared by the write and read paths, so both always agree on a hit
    always_comb
    begin
        sel_port3_drive  = 1'b0;
        sel_port4_drive  = 1'b0;
        sel_port4_latch  = 1'b0;
        sel_port3_bypass = 1'b0;
        sel_mapped       = 1'b1;
        unique case (sfr_addr)
            `GPC_PORT3_DRIVE_OFS:  sel_port3_drive  = 1'b1;
            `GPC_PORT4_DRIVE_OFS:  sel_port4_drive  = 1'b1;
            `GPC_PORT4_DATA_OFS:   sel_port4_latch  = 1'b1;
            `GPC_PORT3_BYPASS_OFS: sel_port3_bypass = 1'b1;
            // other addresses belong to other blocks of the core
            default:               sel_mapped       = 1'b0;
        endcase
    end

    // and-or mux: the selects are one-hot, so at most one term is live
    always_comb
    begin
        read_mux = `GPC_UNMAPPED_READ;
        if (sel_mapped)
        begin
            read_mux = (port3_drive_select_q    & {`GPC_PINS{sel_port3_drive}})
                     | (port4_drive_select_q    & {`GPC_PINS{sel_port4_drive}})
                     | (port4_level             & {`GPC_PINS{sel_port4_latch}})
                     | (port3_crossbar_bypass_q & {`GPC_PINS{sel_port3_bypass}});
        end
    end

    always_comb
    begin
        port3_drive_select_d = port3_drive_select_q;
        if (sfr_wr && sel_port3_drive)
        begin
            port3_drive_select_d = sfr_wdata;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            port3_drive_select_q <= `GPC_PORT3_DRIVE_RST;
        end
        else
        begin
            port3_drive_select_q <= port3_drive_select_d;
        end
    end

    always_comb
    begin
        port4_drive_select_d = port4_drive_select_q;
        if (sfr_wr && sel_port4_drive)
        begin
            port4_drive_select_d = sfr_wdata;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            port4_drive_select_q <= `GPC_PORT4_DRIVE_RST;
        end
        else
        begin
            port4_drive_select_q <= port4_drive_select_d;
        end
    end

    always_comb
    begin
        port4_data_latch_d = port4_data_latch_q;
        if (sfr_wr && sel_port4_latch)
        begin
            port4_data_latch_d = sfr_wdata;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            port4_data_latch_q <= `GPC_PORT4_DATA_RST;
        end
        else
        begin
            port4_data_latch_q <= port4_data_latch_d;
        end
    end

    always_comb
    begin
        port3_crossbar_bypass_d = port3_crossbar_bypass_q;
        if (sfr_wr && sel_port3_bypass)
        begin
            port3_crossbar_bypass_d = sfr_wdata;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            port3_crossbar_bypass_q <= `GPC_PORT3_BYPASS_RST;
        end
        else
        begin
            port3_crossbar_bypass_q <= port3_crossbar_bypass_d;
        end
    end

    // read data holds until the next read, so a stalled core can still pick it up
    always_comb
    begin
        rdata_d = rdata_q;
        if (sfr_rd)
        begin
            rdata_d = read_mux;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            rdata_q <= `GPC_UNMAPPED_READ;
        end
        else
        begin
            rdata_q <= rdata_d;
        end
    end

    for (genvar i = 0; i < `GPC_PINS; i++)
    begin : g_pins
        gpc_pin_cell u_port3
        (
            .digital_en (port3_input_config[i]),
            .push_pull  (port3_drive_select_q[i]),
            .drive_data (port3_data[i]),
            .pin_in     (port3_pin_in[i]),
            .pin_out    (port3_pin_out[i]),
            .pin_oe     (port3_pin_oe[i]),
            .pin_level  (port3_digital_in[i]),
            .pullup_en  (port3_pullup_en[i])
        );
        // port 4 has no analog mode, so its pins are always digital
        gpc_pin_cell u_port4
        (
            .digital_en (1'b1),
            .push_pull  (port4_drive_select_q[i]),
            .drive_data (port4_data_latch_q[i]),
            .pin_in     (port4_pin_in[i]),
            .pin_out    (port4_pin_out_c[i]),
            .pin_oe     (port4_pin_oe_c[i]),
            .pin_level  (port4_level[i]),
            .pullup_en  (port4_pullup_c[i])
        );
    end

    assign sfr_rdata           = rdata_q;
    // software is expected to bypass pins it claims itself; hardware just forwards the mask
    assign port3_crossbar_skip = port3_crossbar_bypass_q;
    assign port4_pin_out       = port4_pin_out_c;
    assign port4_pin_oe        = port4_pin_oe_c;
    assign port4_pullup_en     = port4_pullup_c;
endmodule : gpc_ports

// ---- tb/gpc_chk.sv ----
// Purpose: port-side checks
// Assumes: single clock, sync reset
// Notes: bound into gpc_ports
`timescale 1ns/100ps
module gpc_chk
    import gpc_pkg::*;
(
    input wire logic         clock,
    input wire logic         rst_n,
    input wire logic         sfr_wr,
    input wire logic         sfr_rd,
    input wire gpc_addr_type sfr_addr,
    input wire gpc_byte_type sfr_wdata,
    input wire gpc_byte_type sfr_rdata,
    input wire gpc_byte_type port3_input_config,
    input wire gpc_byte_type port3_data,
    input wire gpc_byte_type port3_pin_in,
    input wire gpc_byte_type port3_pin_out,
    input wire gpc_byte_type port3_pin_oe,
    input wire gpc_byte_type port3_pullup_en,
    input wire gpc_byte_type port3_digital_in,
    input wire gpc_byte_type port3_crossbar_skip,
    input wire gpc_byte_type port4_pin_in,
    input wire gpc_byte_type port4_pin_out,
    input wire gpc_byte_type port4_pin_oe
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    chk_p3_drive_mode: assert property (sfr_wr && sfr_addr == 8'hae |=>
        ((port3_pin_oe ^ ($past(sfr_wdata) | ~port3_data)) & port3_input_config) == 8'h00) else $error("p3 oe");
    chk_p3_out_value: assert property (port3_pin_out == (port3_data & port3_pin_oe & port3_input_config))
        else $error("p3 out");
    chk_p3_analog_off: assert property (((port3_pin_oe | port3_pullup_en) & ~port3_input_config) == 8'h00)
        else $error("p3 analog");
    chk_p3_rx_gate: assert property (port3_digital_in == (port3_pin_in & port3_input_config))
        else $error("p3 rx");
    chk_port4_latch_load: assert property (sfr_wr && sfr_addr == 8'hb5 |=>
        (port4_pin_out | ~port4_pin_oe) == $past(sfr_wdata)) else $error("port 4 latch");
    chk_port4_read_pin: assert property (sfr_rd && sfr_addr == 8'hb5 |=> sfr_rdata == $past(port4_pin_in))
        else $error("port 4 readback");
    chk_p3_skip_load: assert property (sfr_wr && sfr_addr == 8'hd7 |=> port3_crossbar_skip == $past(sfr_wdata))
        else $error("skip");
    cov_port4_write: cover property (sfr_wr && sfr_addr == 8'hb5);
    cov_port4_read: cover property (sfr_rd && sfr_addr == 8'hb5);
    cov_p3_mode: cover property (sfr_wr && sfr_addr == 8'hae);
endmodule : gpc_chk
bind gpc_ports gpc_chk chk
(
    .clock               (clock),
    .rst_n               (rst_n),
    .sfr_wr              (sfr_wr),
    .sfr_rd              (sfr_rd),
    .sfr_addr            (sfr_addr),
    .sfr_wdata           (sfr_wdata),
    .sfr_rdata           (sfr_rdata),
    .port3_input_config  (port3_input_config),
    .port3_data          (port3_data),
    .port3_pin_in        (port3_pin_in),
    .port3_pin_out       (port3_pin_out),
    .port3_pin_oe        (port3_pin_oe),
    .port3_pullup_en     (port3_pullup_en),
    .port3_digital_in    (port3_digital_in),
    .port3_crossbar_skip (port3_crossbar_skip),
    .port4_pin_in        (port4_pin_in),
    .port4_pin_out       (port4_pin_out),
    .port4_pin_oe        (port4_pin_oe)
);

// ---- tb/gpc_pins.sv ----
// Purpose: pin model for ports 3 and 4
// Assumes: every pin has a pull-up
// Notes: hold_low stands for an outside source pulling pins down
`timescale 1ns/100ps
module gpc_pins
    import gpc_pkg::*;
(
    input  wire gpc_byte_type port3_pin_out,
    input  wire gpc_byte_type port3_pin_oe,
    input  wire gpc_byte_type port4_pin_out,
    input  wire gpc_byte_type port4_pin_oe,
    input  wire gpc_byte_type port4_hold_low,
    output gpc_byte_type      port3_pin_in,
    output gpc_byte_type      port4_pin_in
);
    // a released pin goes to the pull-up level unless port4_hold_low pulls it down, never keeps its last value
    assign port3_pin_in = port3_pin_out | ~port3_pin_oe;
    assign port4_pin_in = (port4_pin_out | ~port4_pin_oe) & ~port4_hold_low;
endmodule : gpc_pins

// ---- tb/tb.sv ----
// Purpose: bench for gpc_ports
// Assumes: inputs move 1 ns after the rising edge
// Notes: pins come from gpc_pins
`timescale 1ns/100ps
module tb;
    import gpc_pkg::*;
    logic         clock = 0, rst_n = 0, sfr_wr = 0, sfr_rd = 0;
    gpc_addr_type sfr_addr = 8'h00;
    gpc_byte_type sfr_wdata = 8'h00, port3_input_config = 8'hff, port3_data = 8'hff, port4_hold_low = 8'h00;
    gpc_byte_type sfr_rdata, port3_pin_in, port3_pin_out, port3_pin_oe, port3_pullup_en, port3_digital_in;
    gpc_byte_type port3_crossbar_skip, port4_pin_in, port4_pin_out, port4_pin_oe, port4_pullup_en;
    int           n_errors = 0, n_compared = 0;
    gpc_ports uut
    (
        .clock               (clock),
        .rst_n               (rst_n),
        .sfr_wr              (sfr_wr),
        .sfr_rd              (sfr_rd),
        .sfr_addr            (sfr_addr),
        .sfr_wdata           (sfr_wdata),
        .sfr_rdata           (sfr_rdata),
        .port3_input_config  (port3_input_config),
        .port3_data          (port3_data),
        .port3_pin_in        (port3_pin_in),
        .port3_pin_out       (port3_pin_out),
        .port3_pin_oe        (port3_pin_oe),
        .port3_pullup_en     (port3_pullup_en),
        .port3_digital_in    (port3_digital_in),
        .port3_crossbar_skip (port3_crossbar_skip),
        .port4_pin_in        (port4_pin_in),
        .port4_pin_out       (port4_pin_out),
        .port4_pin_oe        (port4_pin_oe),
        .port4_pullup_en     (port4_pullup_en)
    );
    gpc_pins pins
    (
        .port3_pin_out  (port3_pin_out),
        .port3_pin_oe   (port3_pin_oe),
        .port4_pin_out  (port4_pin_out),
        .port4_pin_oe   (port4_pin_oe),
        .port4_hold_low (port4_hold_low),
        .port3_pin_in   (port3_pin_in),
        .port4_pin_in   (port4_pin_in)
    );
    always #20 clock = ~clock;
    task automatic cmp(input gpc_byte_type got, input gpc_byte_type exp);
        n_compared++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    task automatic acc(input logic w, input gpc_addr_type a, input gpc_byte_type d);
        @(posedge clock) #1;
        {sfr_wr, sfr_rd, sfr_addr, sfr_wdata} = {w, !w, a, d};
        @(posedge clock) #1;
        {sfr_wr, sfr_rd} = 2'b00;
    endtask : acc
    task automatic test_done;
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : test_done
    // reset values, port 4 read shows pulled-up pins, unmapped reads 0x00
    task automatic t_reset;
        gpc_addr_type ra[5] = '{8'hae, 8'haf, 8'hb5, 8'hd7, 8'h00};
        gpc_byte_type rv[5] = '{8'h00, 8'h00, 8'hff, 8'h00, 8'h00};
        foreach (ra[i])
        begin
            acc(0, ra[i], 8'h00);
            cmp(sfr_rdata, rv[i]);
        end
    endtask : t_reset
    task automatic t_port4;
        acc(1, 8'hb5, 8'h0f);
        cmp(port4_pin_oe, 8'hf0);
        cmp(port4_pin_out, 8'h00);
        cmp(port4_pullup_en, 8'hff);
        acc(0, 8'hb5, 8'h00);
        cmp(sfr_rdata, 8'h0f);
        acc(1, 8'hb5, 8'hff);
        port4_hold_low = 8'h81;
        acc(0, 8'hb5, 8'h00);
        cmp(sfr_rdata, 8'h7e);
        port4_hold_low = 8'h00;
        acc(1, 8'haf, 8'ha5);
        cmp(port4_pin_oe, 8'ha5);
        cmp(port4_pin_out, 8'ha5);
        acc(1, 8'hb5, 8'h00);
        cmp(port4_pin_oe, 8'hff);
        cmp(port4_pin_out, 8'h00);
    endtask : t_port4
    // upper pins digital, lower pins analog where drive-select must not matter
    task automatic t_port3;
        port3_input_config = 8'hf0;
        port3_data = 8'h55;
        acc(1, 8'hae, 8'hff);
        cmp(port3_pin_oe, 8'hf0);
        cmp(port3_pullup_en, 8'hf0);
        cmp(port3_digital_in, 8'h50);
        cmp(port3_pin_out, 8'h50);
        acc(1, 8'hae, 8'h00);
        cmp(port3_pin_oe, 8'ha0);
        cmp(port3_pin_out, 8'h00);
        acc(1, 8'hd7, 8'h3c);
        cmp(port3_crossbar_skip, 8'h3c);
        acc(1, 8'h00, 8'hff);
        acc(0, 8'hd7, 8'h00);
        cmp(sfr_rdata, 8'h3c);
    endtask : t_port3
    // a reset in mid-run must bring back every reset value written over above
    task automatic t_midreset;
        @(posedge clock) #1;
        rst_n = 0;
        repeat (2) @(posedge clock);
        #1 rst_n = 1;
        cmp(port3_crossbar_skip, 8'h00);
        cmp(port4_pin_oe, 8'h00);
        cmp(port4_pin_out, 8'h00);
        t_reset();
    endtask : t_midreset
    initial
    begin
        #20000;
        n_errors++;
        test_done();
    end
    initial
    begin
        repeat (10) @(posedge clock);
        #1 rst_n = 1;
        t_reset();
        t_port4();
        t_port3();
        t_midreset();
        test_done();
    end
endmodule : tb
